// >>> src/dsw_pkg.sv
// Contract
// RULE1: Bit 0 is latched summary fault; one means fail seen, zero after reset.
// RULE2: Bits 2 to 7 show live tracker settled state; default one.
// RULE3: Bits 8 and 9 latch start type per rail; zero cold, one warm.
// RULE4: Bit 10 shows live watchdog window phase; one means closed window.
// RULE5: Bits 11 to 13 show live rail reset state; one means reset active.
// RULE6: Prewarning or latched supervision fault (bit 14) pulls error pin low, sets fault.
// RULE7: A cold start indication also pulls error pin low and sets fault.
// RULE8: Tracker switched on but unsettled after 1 ms pulls error low, sets fault.
// RULE9: Word shifts out least significant bit first, first bit with first clock.
// RULE10: Data output is released to high impedance when chip select goes high.
// RULE11: Cold start when main rail fell below 3.3 V, else warm start.
// RULE12: Latched flags clear after a completed frame read them and cause is gone.
package dsw_pkg;
	localparam int        WORD_W       = 16;
	localparam int        NUM_TRK      = 6;
	localparam int        NUM_RST      = 3;
	localparam int        BIT_FAULT    = 0;
	localparam int        BIT_TEMP     = 1;
	localparam int        BIT_TRK      = 2;
	localparam int        BIT_START1   = 8;
	localparam int        BIT_START2   = 9;
	localparam int        BIT_WINDOW   = 10;
	localparam int        BIT_RST      = 11;
	localparam int        BIT_SUPV     = 14;
	localparam int        BIT_BUCK     = 15;
	localparam int        SYS_CLK_HZ   = 50_000_000;
	localparam int        SETTLE_US    = 1000;
	localparam int        SETTLE_CYC   = SETTLE_US * (SYS_CLK_HZ / 1_000_000);
	localparam logic [15:0] TRK_CNT_W1 = 16'hffff;
	localparam logic [5:0] TRK_RST     = 6'h3f;
	localparam logic [3:0] BITCNT_LAST = 4'hf;
endpackage : dsw_pkg

// >>> src/dsw_top.sv
`timescale 1ns/1ns
module dsw_top #(
	parameter int SETTLE_CYCLES = dsw_pkg::SETTLE_CYC
) (
	input  wire logic                        sys_clk,
	input  wire logic                        rstn,
	input  wire logic                        spi_clk,
	input  wire logic                        spi_cs_n,
	output logic                             spi_do,
	output logic                             spi_do_oe,
	input  wire logic                        temp_warn,
	input  wire logic [dsw_pkg::NUM_TRK-1:0] tracker_on,
	input  wire logic [dsw_pkg::NUM_TRK-1:0] tracker_settled_flag,
	input  wire logic                        main_rail_low,
	input  wire logic                        second_rail_low,
	input  wire logic                        window_phase_flag,
	input  wire logic [dsw_pkg::NUM_RST-1:0] rail_reset_flag,
	input  wire logic                        supervision_fault,
	input  wire logic                        buck_on_flag,
	output logic                             error_n,
	output logic [dsw_pkg::WORD_W-1:0]       diag_word
);
	import dsw_pkg::*;

	// Two-stage synchronisers; all pins are asynchronous to sys_clk
	localparam int SW = 3 + 2*NUM_TRK + 2 + 1 + NUM_RST + 1 + 1;
	// Idle pin levels, so no false select edge or settled drop follows reset
	localparam logic [SW-1:0] SYNC_IDLE = {1'b0, 1'b1, 1'b0, {NUM_TRK{1'b0}}, TRK_RST, 2'b00,
		1'b0, {NUM_RST{1'b0}}, 2'b01};
	logic [SW-1:0] raw_in;
	logic [SW-1:0] sync1_r;
	logic [SW-1:0] sync2_r;
	assign raw_in = {spi_clk, spi_cs_n, temp_warn, tracker_on, tracker_settled_flag,
		main_rail_low, second_rail_low, window_phase_flag, rail_reset_flag,
		supervision_fault, buck_on_flag};
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			sync1_r <= SYNC_IDLE;
			sync2_r <= SYNC_IDLE;
		end else begin
			sync1_r <= raw_in;
			sync2_r <= sync1_r;
		end
	end

	logic                sclk_s, cs_n_s, temp_s, low1_s, low2_s, win_s, supv_s, buck_s;
	logic [NUM_TRK-1:0]  on_s, set_s;
	logic [NUM_RST-1:0]  rst_s;
	assign {sclk_s, cs_n_s, temp_s, on_s, set_s, low1_s, low2_s, win_s, rst_s,
		supv_s, buck_s} = sync2_r;

	// State registers
	logic                sclk_d_r, cs_d_r;
	logic [WORD_W-1:0]   shift_r, shift_nxt;
	logic [3:0]          bcnt_r, bcnt_nxt;
	logic                full_r, full_nxt;
	logic                fault_r, fault_nxt;
	logic                start1_r, start1_nxt, start2_r, start2_nxt;
	logic                supv_r, supv_nxt;
	logic                rd_fault_r, rd_fault_nxt, rd_supv_r, rd_supv_nxt;
	logic [NUM_TRK-1:0]  tmo_r, tmo_nxt;
	logic [15:0]         tcnt_r [NUM_TRK];
	logic [15:0]         tcnt_nxt [NUM_TRK];
	logic                do_r, do_nxt, oe_r, oe_nxt, err_r, err_nxt;
	logic [WORD_W-1:0]   word_r, word_nxt;

	logic                sclk_rise, sclk_fall, cs_fall, cs_rise, frame_done;
	logic                cause_fault, cold_any;
	logic [WORD_W-1:0]   live_word;
	assign sclk_rise  = sclk_s & ~sclk_d_r;
	assign sclk_fall  = ~sclk_s & sclk_d_r;
	assign cs_fall    = ~cs_n_s & cs_d_r;
	assign cs_rise    = cs_n_s & ~cs_d_r;
	assign frame_done = cs_rise & full_r;

	always_comb begin
		cold_any    = ~start1_r | ~start2_r; // [RULE7]
		cause_fault = temp_s | supv_r | cold_any | (|tmo_r); // [RULE6] [RULE8]
		live_word = '0;
		live_word[BIT_FAULT]  = fault_r; // [RULE1]
		live_word[BIT_TEMP]   = temp_s;
		live_word[BIT_TRK +: NUM_TRK] = set_s; // [RULE2]
		live_word[BIT_START1] = start1_r; // [RULE3]
		live_word[BIT_START2] = start2_r;
		live_word[BIT_WINDOW] = win_s; // [RULE4]
		live_word[BIT_RST +: NUM_RST] = rst_s; // [RULE5]
		live_word[BIT_SUPV]   = supv_r;
		live_word[BIT_BUCK]   = buck_s;
	end

	always_comb begin
		shift_nxt  = shift_r;
		bcnt_nxt   = bcnt_r;
		full_nxt   = full_r;
		do_nxt     = do_r;
		oe_nxt     = oe_r;
		fault_nxt  = fault_r | cause_fault; // [RULE1]
		start1_nxt = start1_r;
		start2_nxt = start2_r;
		supv_nxt   = supv_r | supv_s;
		tmo_nxt    = tmo_r;
		word_nxt   = live_word;
		rd_fault_nxt = rd_fault_r;
		rd_supv_nxt  = rd_supv_r;
		if (cs_fall) begin
			// Snapshot taken at select; bit 0 driven at once
			shift_nxt = live_word >> 1; // [RULE9]
			do_nxt    = live_word[0];
			oe_nxt    = 1'b1;
			bcnt_nxt  = '0;
			full_nxt  = 1'b0;
			rd_fault_nxt = live_word[BIT_FAULT]; // [RULE12]
			rd_supv_nxt  = live_word[BIT_SUPV];
		end else if (!cs_n_s && oe_r) begin
			if (sclk_fall) begin
				do_nxt    = shift_r[0]; // [RULE9]
				shift_nxt = shift_r >> 1;
			end
			if (sclk_rise) begin
				if (bcnt_r == BITCNT_LAST)
					full_nxt = 1'b1;
				bcnt_nxt = bcnt_r + 4'h1;
			end
		end
		if (cs_rise) begin
			oe_nxt = 1'b0; // [RULE10]
			do_nxt = 1'b0;
		end
		// Read-then-clear; a live cause keeps the flag set
		// Only flags shown in the snapshot clear; a later set waits a frame
		if (frame_done) begin // [RULE12]
			fault_nxt = cause_fault | (fault_r & ~rd_fault_r);
			supv_nxt  = supv_s | (supv_r & ~rd_supv_r);
			// Timeout cause is gone once the tracker settled or was switched off
			tmo_nxt   = tmo_r & on_s & ~set_s;
		end
		// Warm once rail is up; warm start only reported after clean read
		if (low1_s)
			start1_nxt = 1'b0; // [RULE11]
		else if (frame_done)
			start1_nxt = 1'b1; // [RULE12]
		if (low2_s)
			start2_nxt = 1'b0;
		else if (frame_done)
			start2_nxt = 1'b1;
		for (int i = 0; i < NUM_TRK; i++) begin
			tcnt_nxt[i] = tcnt_r[i];
			if (!on_s[i] || set_s[i])
				tcnt_nxt[i] = '0;
			else if (tcnt_r[i] < 16'(SETTLE_CYCLES))
				tcnt_nxt[i] = tcnt_r[i] + 16'h1;
			if (on_s[i] && !set_s[i] && tcnt_r[i] >= 16'(SETTLE_CYCLES) - 16'h1)
				tmo_nxt[i] = 1'b1; // [RULE8]
		end
		err_nxt = ~(fault_nxt); // [RULE6] [RULE7]
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			sclk_d_r <= 1'b0;
			cs_d_r   <= 1'b1;
			shift_r  <= '0;
			bcnt_r   <= '0;
			full_r   <= 1'b0;
			fault_r  <= 1'b0;
			start1_r <= 1'b0;
			start2_r <= 1'b0;
			supv_r   <= 1'b0;
			rd_fault_r <= 1'b0;
			rd_supv_r  <= 1'b0;
			tmo_r    <= '0;
			do_r     <= 1'b0;
			oe_r     <= 1'b0;
			err_r    <= 1'b1;
			word_r   <= 16'h80fc;
			for (int i = 0; i < NUM_TRK; i++)
				tcnt_r[i] <= '0;
		end else begin
			sclk_d_r <= sclk_s;
			cs_d_r   <= cs_n_s;
			shift_r  <= shift_nxt;
			bcnt_r   <= bcnt_nxt;
			full_r   <= full_nxt;
			fault_r  <= fault_nxt;
			start1_r <= start1_nxt;
			start2_r <= start2_nxt;
			supv_r   <= supv_nxt;
			rd_fault_r <= rd_fault_nxt;
			rd_supv_r  <= rd_supv_nxt;
			tmo_r    <= tmo_nxt;
			do_r     <= do_nxt;
			oe_r     <= oe_nxt;
			err_r    <= err_nxt;
			word_r   <= word_nxt;
			for (int i = 0; i < NUM_TRK; i++)
				tcnt_r[i] <= tcnt_nxt[i];
		end
	end

	assign spi_do    = do_r;
	assign spi_do_oe = oe_r;
	assign error_n   = err_r;
	assign diag_word = word_r;

	sequence s_cs_drop;
		cs_fall;
	endsequence

	a_fault_pin: assert property (@(posedge sys_clk) disable iff (!rstn)
		fault_r |-> !error_n) else $error("error pin not low on fault"); // [RULE6]
	a_cold_fault: assert property (@(posedge sys_clk) disable iff (!rstn)
		(!start1_r || !start2_r) |-> ##1 fault_r) else $error("cold start no fault"); // [RULE7]
	a_temp_fault: assert property (@(posedge sys_clk) disable iff (!rstn)
		temp_s |-> ##1 fault_r) else $error("prewarning no fault"); // [RULE6]
	a_first_bit: assert property (@(posedge sys_clk) disable iff (!rstn)
		s_cs_drop |-> ##1 (spi_do_oe && spi_do == $past(live_word[0])))
		else $error("first bit wrong"); // [RULE9]
	a_do_release: assert property (@(posedge sys_clk) disable iff (!rstn)
		cs_rise |-> ##1 !spi_do_oe) else $error("output not released"); // [RULE10]
	a_cold_detect: assert property (@(posedge sys_clk) disable iff (!rstn)
		low1_s |-> ##1 !start1_r) else $error("cold start missed"); // [RULE11]
	a_trk_timeout: assert property (@(posedge sys_clk) disable iff (!rstn)
		(on_s[0] && !set_s[0] && tcnt_r[0] >= 16'(SETTLE_CYCLES) - 16'h1) |-> ##1 tmo_r[0])
		else $error("settle timeout missed"); // [RULE8]
	a_fault_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
		(fault_r && !frame_done) |-> ##1 fault_r) else $error("fault cleared early"); // [RULE12]
	a_word_bits: assert property (@(posedge sys_clk) disable iff (!rstn)
		1'b1 |-> ##1 (diag_word[7:2] == $past(set_s) && diag_word[13:11] == $past(rst_s)))
		else $error("live bits wrong"); // [RULE2]
	a_window_bit: assert property (@(posedge sys_clk) disable iff (!rstn)
		1'b1 |-> ##1 diag_word[BIT_WINDOW] == $past(win_s)) else $error("window bit wrong"); // [RULE4]
endmodule : dsw_top

// >>> sim/dsw_spi_master.sv
`timescale 1ns/1ns
module dsw_spi_master (
	output logic      spi_clk,
	output logic      spi_cs_n,
	input  wire logic spi_do,
	input  wire logic spi_do_oe
);
	initial begin
		spi_clk = 1'b0;
		spi_cs_n = 1'b1;
	end
	// Sample late in high phase, DO lags the falling edge by the sync delay
	task automatic frame(input int n, output logic [15:0] rx, output logic oe_ok);
		rx = 16'h0000;
		oe_ok = 1'b1;
		spi_cs_n = 1'b0;
		#200;
		for (int i = 0; i < n; i++) begin
			spi_clk = 1'b1;
			// Released line shows the inverse, so a missing enable corrupts data
			#70 rx[i] = spi_do_oe ? spi_do : ~spi_do;
			oe_ok &= spi_do_oe;
			#10 spi_clk = 1'b0;
			#80;
		end
		#100 spi_cs_n = 1'b1;
	endtask : frame
endmodule : dsw_spi_master

// >>> sim/dsw_top_tb_top.sv
`timescale 1ns/1ns
module dsw_top_tb_top;
	import dsw_pkg::*;
	logic               sys_clk = 1'b0;
	logic               rstn = 1'b0;
	logic               spi_clk, spi_cs_n, spi_do, spi_do_oe, error_n, oe_ok;
	logic               temp_warn = 1'b0;
	logic [NUM_TRK-1:0] tracker_on = TRK_RST;
	logic [NUM_TRK-1:0] tracker_settled_flag = TRK_RST;
	logic               main_rail_low = 1'b0;
	logic               second_rail_low = 1'b0;
	logic               window_phase_flag = 1'b0;
	logic [NUM_RST-1:0] rail_reset_flag = 3'h0;
	logic               supervision_fault = 1'b0;
	logic               buck_on_flag = 1'b1;
	logic [WORD_W-1:0]  diag_word, rx;
	int                 fails = 0;
	int                 cmp_count = 0;
	always #10 sys_clk = ~sys_clk;
	dsw_top #(.SETTLE_CYCLES(20)) dut (.sys_clk(sys_clk), .rstn(rstn), .spi_clk(spi_clk),
		.spi_cs_n(spi_cs_n), .spi_do(spi_do), .spi_do_oe(spi_do_oe), .temp_warn(temp_warn),
		.tracker_on(tracker_on), .tracker_settled_flag(tracker_settled_flag),
		.main_rail_low(main_rail_low), .second_rail_low(second_rail_low),
		.window_phase_flag(window_phase_flag), .rail_reset_flag(rail_reset_flag),
		.supervision_fault(supervision_fault), .buck_on_flag(buck_on_flag),
		.error_n(error_n), .diag_word(diag_word));
	dsw_spi_master master (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_do(spi_do),
		.spi_do_oe(spi_do_oe));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	function automatic logic [15:0] live(input logic f, input logic [1:0] st, input logic sv);
		return {buck_on_flag, sv, rail_reset_flag, window_phase_flag, st,
			tracker_settled_flag, temp_warn, f};
	endfunction : live
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask : tick
	task automatic xfer(input int n);
		master.frame(n, rx, oe_ok);
		tick(8);
		chk({15'h0, oe_ok}, 16'h0001, "oe in frame");
		chk({15'h0, spi_do_oe}, 16'h0000, "oe released");
	endtask : xfer
	// Two frames: the first turns start flags warm, the second drops the fault
	task automatic clr(input string m);
		xfer(16);
		xfer(16);
		chk(diag_word, live(1'b0, 2'b11, 1'b0), m);
		chk({15'h0, error_n}, 16'h0001, "error pin idle");
		$display("test %s done", m);
	endtask : clr
	task automatic t_start;
		tick(6);
		xfer(16);
		chk(rx, live(1'b1, 2'b00, 1'b0), "first frame");
		chk({15'h0, error_n}, 16'h0000, "cold error");
		clr("startup");
	endtask : t_start
	task automatic t_live;
		window_phase_flag = 1'b1;
		rail_reset_flag = 3'h5;
		tracker_on = 6'h2a;
		tracker_settled_flag = 6'h2a;
		buck_on_flag = 1'b0;
		tick(6);
		chk(diag_word, live(1'b0, 2'b11, 1'b0), "live word");
		xfer(16);
		chk(rx, live(1'b0, 2'b11, 1'b0), "live frame");
		{window_phase_flag, rail_reset_flag, buck_on_flag} = 5'h01;
		tracker_on = TRK_RST;
		tracker_settled_flag = TRK_RST;
		clr("live");
	endtask : t_live
	task automatic t_faults;
		@(posedge sys_clk) #2 temp_warn = 1'b1;
		tick(6);
		chk(diag_word, live(1'b1, 2'b11, 1'b0), "prewarn");
		chk({15'h0, error_n}, 16'h0000, "prewarn pin");
		temp_warn = 1'b0;
		tick(6);
		xfer(8);
		chk(diag_word, live(1'b1, 2'b11, 1'b0), "short frame");
		clr("prewarn");
		supervision_fault = 1'b1;
		tick(1);
		supervision_fault = 1'b0;
		tick(6);
		chk(diag_word, live(1'b1, 2'b11, 1'b1), "supv latch");
		chk({15'h0, error_n}, 16'h0000, "supv pin");
		clr("supervision");
	endtask : t_faults
	task automatic t_settle;
		tracker_on = 6'h3e;
		tracker_settled_flag = 6'h3e;
		tick(6);
		tracker_on = TRK_RST;
		tick(19);
		chk({15'h0, error_n}, 16'h0001, "settle early");
		tick(7);
		chk(diag_word, live(1'b1, 2'b11, 1'b0), "settle late");
		chk({15'h0, error_n}, 16'h0000, "settle pin");
		tracker_settled_flag = TRK_RST;
		clr("settle");
	endtask : t_settle
	task automatic t_cold;
		{main_rail_low, second_rail_low} = 2'b11;
		tick(6);
		xfer(16);
		chk(diag_word, live(1'b1, 2'b00, 1'b0), "cold rails");
		{main_rail_low, second_rail_low} = 2'b00;
		clr("cold");
	endtask : t_cold
	task automatic results;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : results
	initial begin
		repeat (16) @(posedge sys_clk);
		#2 rstn = 1'b1;
		t_start();
		t_live();
		t_faults();
		t_settle();
		t_cold();
		results();
	end
	initial begin
		#600000;
		fails++;
		results();
	end
endmodule : dsw_top_tb_top
